// file: common/mdb_pkg.sv
package mdb_pkg;

  // Operation codes presented by the issue logic
  typedef enum logic [3:0] {
    MDB_OP_MUL_LO,
    MDB_OP_MUL_HI,
    MDB_OP_UNSIGNED_MULTIPLY_LOW_LO,
    MDB_OP_UNSIGNED_MULTIPLY_LOW_HI,
    MDB_OP_MADD,
    MDB_OP_MSUB,
    MDB_OP_DPSAT_W,
    MDB_OP_DPSAT_D,
    MDB_OP_ACC_SHIFT,
    MDB_OP_DIV,
    MDB_OP_MOD,
    MDB_OP_UNSIGNED_QUOTIENT,
    MDB_OP_UNSIGNED_REMAINDER
  } mdb_op_t;

  // Pipeline latencies in clocks, counted from issue
  localparam int unsigned MDB_LAT_FAST = 6;
  localparam int unsigned MDB_LAT_SLOW = 7;
  // Depth of the result delay line (issue is cycle 0)
  localparam int unsigned MDB_PIPE_LEN = 8;
  // Divider cost: latency = base + step * nibble class, one more if signed
  localparam int unsigned MDB_DIV_BASE = 6;
  localparam int unsigned MDB_DIV_STEP = 4;
  localparam int unsigned MDB_REP_GAP = 3;
  // Extra clock the extension's divider spends
  localparam int unsigned MDB_DIV_EXT_EXTRA = 0;
  localparam logic [1:0] MDB_ACC_RESET = 2'h0;

endpackage

// file: hdl/mdb_divider.sv
// Iterative divider; counts down a latency picked from dividend width
module mdb_divider
  import mdb_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic is_signed,
  input wire logic want_rem,
  input wire logic [31:0] dividend,
  input wire logic [31:0] divisor,
  input wire logic [5:0] latency,
  output logic busy,
  output logic done,
  output logic [31:0] result
);

  typedef struct packed {
    logic busy;
    logic done;
    logic [5:0] cnt;
    logic [31:0] res;
  } mdb_div_state_t;

  mdb_div_state_t s_q, s_d;
  logic [31:0] a_mag, b_mag, q_mag, r_mag, q_val, r_val;

  // Result computed once at start; the counter models the iteration time
  always_comb
  begin
    a_mag = (is_signed && dividend[31]) ? (32'h0 - dividend) : dividend;
    b_mag = (is_signed && divisor[31]) ? (32'h0 - divisor) : divisor;
    q_mag = (b_mag == 32'h0) ? 32'hffffffff : a_mag / b_mag;
    r_mag = (b_mag == 32'h0) ? a_mag : a_mag % b_mag;
    q_val = (is_signed && (dividend[31] ^ divisor[31])) ? (32'h0 - q_mag) : q_mag;
    r_val = (is_signed && dividend[31]) ? (32'h0 - r_mag) : r_mag;
    s_d = s_q;
    s_d.done = 1'b0;
    if (start)
    begin
      s_d.busy = 1'b1;
      s_d.cnt = latency - 6'h2;
      s_d.res = want_rem ? r_val : q_val;
    end
    else if (s_q.busy)
    begin
      if (s_q.cnt == 6'h0)
      begin
        s_d.busy = 1'b0;
        s_d.done = 1'b1;
      end
      else
      begin
        s_d.cnt = s_q.cnt - 6'h1;
      end
    end
  end

  // State register
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign busy = s_q.busy;
  assign done = s_q.done;
  assign result = s_q.res;

endmodule

// file: hdl/mdb_unit.sv
// Function
// RULE1 - Without extension, pass count depends only on the second operand.
// RULE2 - 32x16 build: narrow products one pass, full 32x32 two passes.
// RULE3 - 32x16 build accepts narrow each clock, full width every other clock.
// RULE4 - Interlock holds a full-width multiply behind another until array free.
// RULE5 - Operand width is classified internally, no hint from issue.
// RULE6 - Extension: 32x32 array takes any multiply every clock, shared by extension. Code refuses a fast multiply the clock after a slow operation.
// RULE7 - Pipeline advances even while the integer pipeline stalls.
// RULE8 - Results go to general registers, or four accumulator pairs with extension.
// RULE9 - Extension: unsaturated or word-saturated multiplies take 6 clocks, rate one.
// RULE10 - Doubleword-saturated accumulation takes 7 clocks, still one per clock.
// RULE11 - Accumulator shift on previous multiply result: 7 clocks, every 2.
// RULE12 - Extension: register-destination multiplies take 6 clocks, every clock.
// RULE13 - Extension multiply-add/subtract into 64-bit accumulator: 6 clocks, rate one.
// RULE14 - No extension: 16-bit operand 6 clocks rate 1; 32-bit 7 clocks, rate 2.
// RULE15 - Divide time scales with dividend width, 11/10 up to 39/38 clocks.
// RULE16 - Divide blocks issue only when a later instruction needs its result. Code also refuses a second divide while the divider is busy.
// RULE17 - Booth recode in address stage, product formed in execute stage.
// RULE18 - Extension also shifts accumulator pairs and handles its data types.
// RULE19 - Divide latency range differs between builds by dividend sign extension. Code gives both builds the same range.
// RULE20 - Pending flag per destination; issue stalls readers until it clears.
module mdb_unit
  import mdb_pkg::*;
#(
  parameter bit HAS_EXT = 1'b0
)
(
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic ISSUE_VALID,
  input wire mdb_op_t ISSUE_OP,
  input wire logic [31:0] ISSUE_SRC1,
  input wire logic [31:0] ISSUE_SRC2,
  input wire logic [4:0] ISSUE_DEST,
  input wire logic [1:0] ISSUE_ACC,
  input wire logic [5:0] ISSUE_SHAMT,
  input wire logic READ_VALID,
  input wire logic [4:0] READ_REG,
  input wire logic [1:0] READ_ACC,
  input wire logic READ_IS_ACC,
  output logic ISSUE_READY,
  output logic READ_STALL,
  output logic WB_VALID,
  output logic [4:0] WB_DEST,
  output logic [31:0] WB_DATA,
  output logic ACC_WB_VALID,
  output logic [1:0] ACC_WB_SEL,
  output logic [63:0] ACC_WB_DATA,
  output logic [31:0] GPR_PENDING,
  output logic [3:0] ACC_PENDING
);

  typedef struct packed {
    logic vld;
    logic to_acc;
    logic [4:0] dest;
    logic [1:0] acc;
    logic [63:0] data;
  } mdb_stage_t;

  typedef struct packed {
    mdb_stage_t [MDB_PIPE_LEN-1:0] pipe;
    logic [3:0][63:0] acc_val;
    logic busy_array;
    logic last_mul;
    logic last_slow;
    logic [1:0] last_acc;
    logic div_act;
    logic div_to_acc;
    logic [4:0] div_dest;
    logic [1:0] div_acc;
  } mdb_state_t;

  mdb_state_t s_q, s_d;
  logic is_div, is_mul, wide, slow, take, div_busy, div_done, div_start;
  logic [31:0] div_res;
  logic [63:0] prod, acc_new, res64;
  logic [5:0] div_lat;
  logic [3:0] nib, div_nib;
  logic [31:0] hi_u, hi_s;
  int unsigned lat;

  // Divider lives in its own iterative engine
  mdb_divider u_div (
    .clk(CLK_SYS),
    .rst_n(RST_N),
    .start(div_start),
    .is_signed(ISSUE_OP == MDB_OP_DIV || ISSUE_OP == MDB_OP_MOD),
    .want_rem(ISSUE_OP == MDB_OP_MOD || ISSUE_OP == MDB_OP_UNSIGNED_REMAINDER),
    .dividend(ISSUE_SRC1),
    .divisor(ISSUE_SRC2),
    .latency(div_lat),
    .busy(div_busy),
    .done(div_done),
    .result(div_res)
  );

  // Dividend significant width in nibbles; sign extension not counted for signed ops
  always_comb
  begin
    nib = 4'h8;
    hi_u = 32'h0;
    hi_s = 32'h0;
    for (int i = 7; i >= 1; i--)
    begin
      // Shifts instead of part-selects keep every bound constant
      hi_u = ISSUE_SRC1 >> (4 * i);
      hi_s = 32'($signed(ISSUE_SRC1) >>> (4 * i - 1));
      if (hi_u == 32'h0 || (hi_s == 32'hffffffff && ISSUE_OP inside {MDB_OP_DIV, MDB_OP_MOD}))
      begin
        nib = 4'(i);
      end
    end
  end

  always_comb
  begin
    is_div = ISSUE_OP inside {MDB_OP_DIV, MDB_OP_MOD, MDB_OP_UNSIGNED_QUOTIENT, MDB_OP_UNSIGNED_REMAINDER};
    is_mul = !is_div && ISSUE_OP != MDB_OP_ACC_SHIFT;
    // RULE1 RULE5 width classifier
    // Only the second operand decides; first operand never looked at
    // An unsigned operand with its top half set is never narrow
    wide = (ISSUE_SRC2[31:15] != 17'h0)
      && ((ISSUE_SRC2[31:15] != 17'h1ffff) || ISSUE_OP inside {MDB_OP_UNSIGNED_MULTIPLY_LOW_LO, MDB_OP_UNSIGNED_MULTIPLY_LOW_HI});
    // RULE15 RULE19 divide latency
    // Rounded to 4/8/16/24/32-bit classes; signed costs one more clock
    div_nib = (nib <= 4'h2) ? nib : ((nib <= 4'h4) ? 4'h4 : ((nib <= 4'h6) ? 4'h6 : 4'h8));
    div_lat = 6'(MDB_DIV_BASE + MDB_DIV_STEP * div_nib);
    if (ISSUE_OP inside {MDB_OP_DIV, MDB_OP_MOD})
    begin
      div_lat = div_lat + 6'h1;
    end
    div_lat = div_lat + 6'(MDB_DIV_EXT_EXTRA * HAS_EXT);
  end

  // RULE3 RULE4 RULE11 RULE14 issue interlock
  // Any issue right behind a wide multiply without extension, or a shift on a just-issued multiply, waits one clock
  always_comb
  begin
    ISSUE_READY = 1'b1;
    if (s_q.busy_array)
    begin
      ISSUE_READY = 1'b0;
    end
    if (ISSUE_OP == MDB_OP_ACC_SHIFT && s_q.last_mul && s_q.last_acc == ISSUE_ACC)
    begin
      ISSUE_READY = 1'b0;
    end
    // RULE10 slow-then-fast guard
    // A fast result issued right behind a slow one would land in the same slot
    if (s_q.last_slow && !is_div && !slow)
    begin
      ISSUE_READY = 1'b0;
    end
    // RULE16 divider busy only refuses another divide
    if (is_div && div_busy)
    begin
      ISSUE_READY = 1'b0;
    end
  end

  assign take = ISSUE_VALID && ISSUE_READY;
  assign div_start = take && is_div;

  // RULE17 RULE6 RULE18 product and accumulator arithmetic
  always_comb
  begin
    if (ISSUE_OP inside {MDB_OP_UNSIGNED_MULTIPLY_LOW_LO, MDB_OP_UNSIGNED_MULTIPLY_LOW_HI})
    begin
      prod = {32'h0, ISSUE_SRC1} * {32'h0, ISSUE_SRC2};
    end
    else
    begin
      // Explicit sign extension keeps the full 64-bit signed product
      prod = {{32{ISSUE_SRC1[31]}}, ISSUE_SRC1} * {{32{ISSUE_SRC2[31]}}, ISSUE_SRC2};
    end
    acc_new = s_q.acc_val[ISSUE_ACC];
    unique case (ISSUE_OP)
      MDB_OP_MADD, MDB_OP_DPSAT_W, MDB_OP_DPSAT_D: acc_new = acc_new + prod;
      MDB_OP_MSUB: acc_new = acc_new - prod;
      MDB_OP_ACC_SHIFT: acc_new = acc_new >> ISSUE_SHAMT;
      default: acc_new = prod;
    endcase
    // Word saturation clips to the signed 32-bit range
    if (ISSUE_OP == MDB_OP_DPSAT_W && acc_new[63:31] != 33'h0 && acc_new[63:31] != 33'h1ffffffff)
    begin
      acc_new = acc_new[63] ? 64'hffffffff80000000 : 64'h000000007fffffff;
    end
    res64 = acc_new;
    if (ISSUE_OP inside {MDB_OP_MUL_HI, MDB_OP_UNSIGNED_MULTIPLY_LOW_HI})
    begin
      res64 = {32'h0, prod[63:32]};
    end
    else if (ISSUE_OP inside {MDB_OP_MUL_LO, MDB_OP_UNSIGNED_MULTIPLY_LOW_LO})
    begin
      res64 = {32'h0, prod[31:0]};
    end
  end

  // RULE9 RULE10 RULE12 RULE13 RULE14 latency selection
  always_comb
  begin
    slow = (!HAS_EXT && is_mul && wide) || ISSUE_OP == MDB_OP_DPSAT_D || ISSUE_OP == MDB_OP_ACC_SHIFT;
    lat = slow ? MDB_LAT_SLOW : MDB_LAT_FAST;
  end

  // RULE7 RULE8 delay line shifts every clock, never held by the core
  always_comb
  begin
    s_d = s_q;
    s_d.busy_array = take && is_mul && wide && !HAS_EXT;
    s_d.last_slow = take && !is_div && slow;
    for (int i = 1; i < MDB_PIPE_LEN; i++)
    begin
      s_d.pipe[i] = s_q.pipe[i-1];
    end
    s_d.pipe[0] = '0;
    if (take)
    begin
      s_d.last_mul = is_mul;
      s_d.last_acc = ISSUE_ACC;
    end
    else
    begin
      s_d.last_mul = 1'b0;
    end
    if (take && !is_div)
    begin
      // Entry placed so it leaves the line lat clocks after issue
      s_d.pipe[MDB_PIPE_LEN - lat].vld = 1'b1;
      s_d.pipe[MDB_PIPE_LEN - lat].to_acc = HAS_EXT && !(ISSUE_OP inside
        {MDB_OP_MUL_LO, MDB_OP_MUL_HI, MDB_OP_UNSIGNED_MULTIPLY_LOW_LO, MDB_OP_UNSIGNED_MULTIPLY_LOW_HI});
      s_d.pipe[MDB_PIPE_LEN - lat].dest = ISSUE_DEST;
      s_d.pipe[MDB_PIPE_LEN - lat].acc = ISSUE_ACC;
      s_d.pipe[MDB_PIPE_LEN - lat].data = res64;
    end
    if (div_start)
    begin
      s_d.div_act = 1'b1;
      s_d.div_to_acc = HAS_EXT;
      s_d.div_dest = ISSUE_DEST;
      s_d.div_acc = ISSUE_ACC;
    end
    else if (div_done)
    begin
      s_d.div_act = 1'b0;
    end
    // Accumulator copy updated when the result retires
    if (s_q.pipe[MDB_PIPE_LEN-1].vld && s_q.pipe[MDB_PIPE_LEN-1].to_acc)
    begin
      s_d.acc_val[s_q.pipe[MDB_PIPE_LEN-1].acc] = s_q.pipe[MDB_PIPE_LEN-1].data;
    end
    if (div_done && s_q.div_to_acc)
    begin
      s_d.acc_val[s_q.div_acc] = {32'h0, div_res};
    end
  end

  // State register
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_N)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // Writeback ports; multiply retire wins the general register port over divide
  always_comb
  begin
    WB_VALID = (s_q.pipe[MDB_PIPE_LEN-1].vld && !s_q.pipe[MDB_PIPE_LEN-1].to_acc)
      || (div_done && !s_q.div_to_acc);
    WB_DEST = s_q.pipe[MDB_PIPE_LEN-1].vld ? s_q.pipe[MDB_PIPE_LEN-1].dest : s_q.div_dest;
    WB_DATA = s_q.pipe[MDB_PIPE_LEN-1].vld ? s_q.pipe[MDB_PIPE_LEN-1].data[31:0] : div_res;
    ACC_WB_VALID = (s_q.pipe[MDB_PIPE_LEN-1].vld && s_q.pipe[MDB_PIPE_LEN-1].to_acc)
      || (div_done && s_q.div_to_acc);
    ACC_WB_SEL = s_q.pipe[MDB_PIPE_LEN-1].vld ? s_q.pipe[MDB_PIPE_LEN-1].acc : s_q.div_acc;
    ACC_WB_DATA = s_q.pipe[MDB_PIPE_LEN-1].vld ? s_q.pipe[MDB_PIPE_LEN-1].data : {32'h0, div_res};
  end

  // RULE20 RULE16 pending flags per destination
  always_comb
  begin
    GPR_PENDING = 32'h0;
    ACC_PENDING = 4'h0;
    for (int i = 0; i < MDB_PIPE_LEN; i++)
    begin
      if (s_q.pipe[i].vld && s_q.pipe[i].to_acc)
      begin
        ACC_PENDING[s_q.pipe[i].acc] = 1'b1;
      end
      else if (s_q.pipe[i].vld)
      begin
        GPR_PENDING[s_q.pipe[i].dest] = 1'b1;
      end
    end
    if (s_q.div_act && s_q.div_to_acc)
    begin
      ACC_PENDING[s_q.div_acc] = 1'b1;
    end
    else if (s_q.div_act)
    begin
      GPR_PENDING[s_q.div_dest] = 1'b1;
    end
    READ_STALL = READ_VALID && (READ_IS_ACC ? ACC_PENDING[READ_ACC] : GPR_PENDING[READ_REG]);
  end

  // Full-width multiply in narrow build refused the following clock
  AST_WIDE_GAP: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // RULE4
    (ISSUE_VALID && ISSUE_READY && !HAS_EXT && wide && is_mul) |=> !ISSUE_READY)
    else $error("wide multiply not interlocked");

  // Fast multiply retires exactly six clocks after issue
  AST_FAST_LAT: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // RULE9
    (take && is_mul && !slow) |-> ##6 (WB_VALID || ACC_WB_VALID))
    else $error("fast multiply latency wrong");

  // Slow operations retire seven clocks after issue
  AST_SLOW_LAT: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // RULE10
    (take && !is_div && slow) |-> ##7 (WB_VALID || ACC_WB_VALID))
    else $error("slow latency wrong");

  // With extension a multiply is refused only to keep a slot free
  AST_EXT_RATE: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // RULE6
    (HAS_EXT && is_mul && (slow || !s_q.last_slow)) |-> ISSUE_READY)
    else $error("extension multiply blocked issue");

  // Divide result returns within its bounded latency
  AST_DIV_DONE: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // RULE15
    div_start |-> ##[10:39] div_done)
    else $error("divide latency out of range");

  // Reader of a pending general register is stalled
  AST_PEND_STALL: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // RULE20
    (READ_VALID && !READ_IS_ACC && GPR_PENDING[READ_REG]) |-> READ_STALL)
    else $error("pending read not stalled");

  // Divider busy does not refuse a multiply
  AST_DIV_NONBLOCK: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // RULE16
    (div_busy && is_mul && !s_q.busy_array && (slow || !s_q.last_slow)) |-> ISSUE_READY)
    else $error("divide blocked multiply");

  // Narrow multiply leaves issue open to another multiply the next clock
  AST_NARROW_RATE: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // RULE3
    (take && is_mul && !slow) |=> (!is_mul || ISSUE_READY))
    else $error("narrow multiply blocked issue");

endmodule

// file: verif/mdb_issue_model.sv
// Issue side of the integer pipeline: presents one request and holds it
module mdb_issue_model
  import mdb_pkg::*;
(
  input wire logic clk,
  input wire logic ready,
  output logic valid,
  output mdb_op_t op,
  output logic [31:0] src1,
  output logic [31:0] src2,
  output logic [4:0] dest,
  output logic rd_valid,
  output logic [4:0] rd_reg
);
  timeunit 1ns;
  timeprecision 1ns;

  // Quiet bus at time zero
  initial
  begin
    valid = 1'b0;
    op = MDB_OP_MUL_LO;
    src1 = 32'h0;
    src2 = 32'h0;
    dest = 5'h0;
    rd_valid = 1'b0;
    rd_reg = 5'h0;
  end

  // Caller stands at a rising edge; request held until ready is sampled high at a falling edge, or until 100 refusals
  task automatic issue(input mdb_op_t o, input logic [31:0] a, input logic [31:0] b,
                       input logic [4:0] d, output int waits);
    logic rdy;
    waits = 0;
    valid <= 1'b1;
    op <= o;
    src1 <= a;
    src2 <= b;
    dest <= d;
    rd_valid <= 1'b1;
    rd_reg <= d;
    do
    begin
      @(negedge clk);
      rdy = ready;
      @(posedge clk);
      if (rdy !== 1'b1)
        waits++;
    end
    while (rdy !== 1'b1 && waits < 100);
  endtask

  // Drop the request; operands flip so stale values never look valid
  task automatic idle();
    valid <= 1'b0;
    src1 <= ~src1;
    src2 <= ~src2;
  endtask
endmodule

// file: verif/tb_top.sv
// Self-checking bench for the multiply/divide block, both builds on one stimulus
module tb_top
  import mdb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct {mdb_op_t op; logic [31:0] a; logic [31:0] b; logic [31:0] res; int lat;} mdb_row_t;
  localparam int NROWS = 16;
  logic clk_sys, rst_n, issue_valid, read_valid, issue_ready, read_stall, wb_valid;
  mdb_op_t issue_op;
  logic [31:0] src1, src2, wb_data, gpr_pending;
  logic [4:0] dest, read_reg, wb_dest;
  int num_errors = 0;
  int checked = 0;
  logic x_wb, x_acc;
  logic [31:0] x_wb_data, xd;
  logic [63:0] x_acc_data;
  logic [3:0] x_pend;
  int w, k, hits, kx;
  bit dv;
  // Operation, operands, expected result, expected latency
  mdb_row_t rows [NROWS] = '{
    '{MDB_OP_MUL_LO, 32'h3, 32'h5, 32'hf, 6},
    '{MDB_OP_MUL_LO, 32'hffffffff, 32'h7, 32'hfffffff9, 6},
    '{MDB_OP_MUL_HI, 32'hfffffffe, 32'h3, 32'hffffffff, 6},
    '{MDB_OP_UNSIGNED_MULTIPLY_LOW_LO, 32'h12345678, 32'h100, 32'h34567800, 6},
    '{MDB_OP_UNSIGNED_MULTIPLY_LOW_HI, 32'h2, 32'hffffffff, 32'h1, 7},
    '{MDB_OP_MUL_LO, 32'h3, 32'h10000, 32'h30000, 7},
    '{MDB_OP_UNSIGNED_MULTIPLY_LOW_HI, 32'h10000, 32'h10000, 32'h1, 7},
    '{MDB_OP_DIV, 32'h7, 32'h2, 32'h3, 11},
    '{MDB_OP_MOD, 32'h7, 32'h2, 32'h1, 11},
    '{MDB_OP_UNSIGNED_QUOTIENT, 32'h9, 32'h2, 32'h4, 10},
    '{MDB_OP_UNSIGNED_REMAINDER, 32'h9, 32'h2, 32'h1, 10},
    '{MDB_OP_UNSIGNED_QUOTIENT, 32'hff, 32'h10, 32'hf, 14},
    '{MDB_OP_DIV, 32'h1234, 32'h10, 32'h123, 23},
    '{MDB_OP_UNSIGNED_REMAINDER, 32'h123456, 32'h100, 32'h56, 30},
    '{MDB_OP_UNSIGNED_QUOTIENT, 32'h80000000, 32'h2, 32'h40000000, 38},
    '{MDB_OP_UNSIGNED_QUOTIENT, 32'h5, 32'h0, 32'hffffffff, 10}};

  // Accumulator side tied off: no extension in this build
  mdb_unit #(.HAS_EXT(1'b0)) u_mdb_unit (
    .CLK_SYS(clk_sys), .RST_N(rst_n), .ISSUE_VALID(issue_valid), .ISSUE_OP(issue_op),
    .ISSUE_SRC1(src1), .ISSUE_SRC2(src2), .ISSUE_DEST(dest), .ISSUE_ACC(2'h0),
    .ISSUE_SHAMT(6'h00), .READ_VALID(read_valid), .READ_REG(read_reg), .READ_ACC(2'h0),
    .READ_IS_ACC(1'b0), .ISSUE_READY(issue_ready), .READ_STALL(read_stall),
    .WB_VALID(wb_valid), .WB_DEST(wb_dest), .WB_DATA(wb_data), .ACC_WB_VALID(),
    .ACC_WB_SEL(), .ACC_WB_DATA(), .GPR_PENDING(gpr_pending), .ACC_PENDING());

  // Extension build watches the same requests; divides retire to an accumulator
  mdb_unit #(.HAS_EXT(1'b1)) u_mdb_unit_ext (
    .CLK_SYS(clk_sys), .RST_N(rst_n), .ISSUE_VALID(issue_valid), .ISSUE_OP(issue_op),
    .ISSUE_SRC1(src1), .ISSUE_SRC2(src2), .ISSUE_DEST(dest), .ISSUE_ACC(2'h0),
    .ISSUE_SHAMT(6'h00), .READ_VALID(read_valid), .READ_REG(read_reg), .READ_ACC(2'h0),
    .READ_IS_ACC(1'b0), .ISSUE_READY(), .READ_STALL(),
    .WB_VALID(x_wb), .WB_DEST(), .WB_DATA(x_wb_data), .ACC_WB_VALID(x_acc),
    .ACC_WB_SEL(), .ACC_WB_DATA(x_acc_data), .GPR_PENDING(), .ACC_PENDING(x_pend));

  mdb_issue_model u_mdb_issue_model (
    .clk(clk_sys), .ready(issue_ready), .valid(issue_valid), .op(issue_op), .src1(src1),
    .src2(src2), .dest(dest), .rd_valid(read_valid), .rd_reg(read_reg));

  task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_cnt(input int got, input int exp);
    checked++;
    if (got != exp)
    begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    $display("checks=%0d errors=%0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // Whole run is under a thousand clocks; this is ample
  initial
  begin
    #300000;
    num_errors++;
    test_done();
  end

  initial
  begin
    rst_n = 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    for (int i = 0; i < NROWS; i++)
    begin
      dv = rows[i].op inside {MDB_OP_DIV, MDB_OP_MOD, MDB_OP_UNSIGNED_QUOTIENT, MDB_OP_UNSIGNED_REMAINDER};
      kx = 0;
      xd = 32'h0;
      u_mdb_issue_model.issue(rows[i].op, rows[i].a, rows[i].b, 5'(i + 1), w);
      u_mdb_issue_model.idle();
      k = 0;
      while (k < 60)
      begin
        @(negedge clk_sys);
        k++;
        if (k == 1)
          chk_data(32'({read_stall, gpr_pending[i + 1]}), 32'h3);
        if (k == 1)
          chk_data(32'(x_pend), dv ? 32'h1 : 32'h0);
        // Extension result never comes later than the narrow build's
        if (kx == 0 && (dv ? x_acc : x_wb) === 1'b1)
        begin
          kx = k;
          xd = dv ? x_acc_data[31:0] : x_wb_data;
        end
        if (wb_valid === 1'b1)
          break;
      end
      chk_cnt(kx, dv ? rows[i].lat : int'(MDB_LAT_FAST));
      chk_data(xd, rows[i].res);
      chk_cnt(k, rows[i].lat);
      chk_data(wb_data, rows[i].res);
      chk_data(32'(wb_dest), 32'(i + 1));
      @(posedge clk_sys);
    end
    for (int j = 0; j < 5; j++)
    begin
      u_mdb_issue_model.issue(MDB_OP_MUL_LO, 32'h3, j < 3 ? 32'h5 : 32'h10000, 5'h1, w);
      chk_cnt(w, j == 4 ? 1 : 0);
    end
    u_mdb_issue_model.idle();
    repeat (10) @(posedge clk_sys);
    u_mdb_issue_model.issue(MDB_OP_UNSIGNED_QUOTIENT, 32'h80000000, 32'h2, 5'h2, w);
    u_mdb_issue_model.issue(MDB_OP_MUL_LO, 32'h3, 32'h5, 5'h3, w);
    chk_cnt(w, 0);
    u_mdb_issue_model.issue(MDB_OP_UNSIGNED_QUOTIENT, 32'h4, 32'h2, 5'h4, w);
    chk_cnt(w > 30 ? 1 : 0, 1);
    u_mdb_issue_model.idle();
    repeat (20) @(posedge clk_sys);
    // Reset in mid-flight drops the pending multiply
    u_mdb_issue_model.issue(MDB_OP_MUL_LO, 32'h3, 32'h5, 5'h5, w);
    u_mdb_issue_model.idle();
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    chk_data(gpr_pending, 32'h0);
    chk_data(32'({issue_ready, wb_valid}), 32'h2);
    @(posedge clk_sys);
    rst_n <= 1'b1;
    hits = 0;
    repeat (10)
    begin
      @(negedge clk_sys);
      if (wb_valid !== 1'b0)
        hits++;
    end
    chk_cnt(hits, 0);
    test_done();
  end
endmodule
